// file: cicr_pkg.sv
// Constants and types for the core implementation control register bank.
// Assumes a 32-bit byte-addressed register port on one processor clock.
package cicr_pkg;

  // Register byte addresses
  localparam logic [31:0] CICR_ADDR_PORT_CTRL = 32'he001e010;
  localparam logic [31:0] CICR_ADDR_PF_CTRL   = 32'he001e014;
  localparam logic [31:0] CICR_ADDR_CORE_PWR  = 32'he001e300;
  localparam logic [31:0] CICR_ADDR_DBG_PWR   = 32'he001e304;
  localparam logic [31:0] CICR_ADDR_CFG_SEL   = 32'he001e700;
  localparam logic [31:0] CICR_ADDR_CFG_RD    = 32'he001e704;

  // Field positions
  localparam int CICR_EN_BIT    = 0;
  localparam int CICR_SIZE_LSB  = 1;
  localparam int CICR_PF_BIT    = 0;
  localparam int CICR_CORE_LSB  = 0;
  localparam int CICR_EXT_LSB   = 4;
  localparam int CICR_RAM_LSB   = 8;
  localparam int CICR_DBG_LSB   = 0;

  // Power request encodings
  localparam logic [1:0] CICR_PWR_ON     = 2'h0;
  localparam logic [1:0] CICR_PWR_CLKOFF = 2'h1;
  localparam logic [1:0] CICR_PWR_RET    = 2'h2;
  localparam logic [1:0] CICR_PWR_OFF    = 2'h3;

  // Reset values and port size limits
  localparam logic        CICR_PF_RESET   = 1'h1;
  localparam logic [1:0]  CICR_PWR_RESET  = CICR_PWR_OFF;
  localparam logic [31:0] CICR_SEL_RESET  = 32'h0;
  localparam logic [2:0]  CICR_SIZE_ZERO  = 3'h0;
  localparam logic [2:0]  CICR_SIZE_MAX   = 3'h4;

  // Configuration item selector codes
  localparam logic [31:0] CICR_CFG_ICACHESZ = 32'h1;
  localparam logic [31:0] CICR_CFG_DCACHESZ = 32'h2;
  localparam logic [31:0] CICR_CFG_ECC      = 32'h3;
  localparam logic [31:0] CICR_CFG_FPU      = 32'h4;
  localparam logic [31:0] CICR_CFG_MVE      = 32'h5;
  localparam logic [31:0] CICR_CFG_SECEXT   = 32'h6;
  localparam logic [31:0] CICR_CFG_MPU_NS   = 32'h8;
  localparam logic [31:0] CICR_CFG_MPU_S    = 32'h9;
  localparam logic [31:0] CICR_CFG_SAU      = 32'ha;
  localparam logic [31:0] CICR_CFG_L1RSTDIS = 32'h4b;
  localparam logic [31:0] CICR_CFG_MEMALIAS = 32'h4c;

  // One-hot register select
  typedef enum logic [6:0] {
    CICR_R_NONE = 7'h01,
    CICR_R_PORT = 7'h02,
    CICR_R_PF   = 7'h04,
    CICR_R_CPWR = 7'h08,
    CICR_R_DPWR = 7'h10,
    CICR_R_CSEL = 7'h20,
    CICR_R_CRD  = 7'h40
  } cicr_reg_t;

  // Power requests toward the power controller
  typedef struct packed {
    logic [1:0] core;
    logic [1:0] ext;
    logic [1:0] ram;
    logic [1:0] dbg;
  } cicr_pwr_t;

  // Whole block state
  typedef struct packed {
    logic        port_en;
    logic [2:0]  port_size;
    logic        pf_en;
    cicr_pwr_t   pwr;
    logic [31:0] sel;
    logic [31:0] rdata;
    logic        fault;
  } cicr_state_t;

endpackage

// file: cicr_regs.sv
// Core implementation control register bank: port, prefetch, power, config.
// Assumes a single-cycle strobe register port and privilege/security tags.
//
// Contract
// - Port size field read-only, five encodings
// - Port size loaded from input at reset
// - Port enable zero routes to main interface
// - Port enable reset value from init input
// - Vendor region always uses peripheral port
// - Non-secure blocked: read zero, ignore writes
// - Unprivileged access: no update, bus fault
// - Prefetch enable bit, resets to one
// - Lookahead fields always read zero
// - No data cache: prefetch register zero
// - RAM request on/off, resets off; code stores all four encodings
// - No caches: RAM request reads zero
// - Extension request four states, absent zero
// - Core request four states, resets off
// - Requests are minima for power channel
// - Debug reserved value acts clock-stopped
// - Debug request reset by debug reset
// - Power registers at fixed addresses
// - Config selector and readback pair
// - Disabled tie-off reports unsupported feature
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module cicr_regs #(
  parameter bit          DCACHE_PRESENT = 1'b1,
  parameter bit          ICACHE_PRESENT = 1'b1,
  parameter bit          EPU_PRESENT    = 1'b1,
  parameter bit          SECEXT_PRESENT = 1'b1,
  parameter bit          ECC_PRESENT    = 1'b0,
  parameter bit          FPU_PRESENT    = 1'b1,
  parameter bit          MVE_PRESENT    = 1'b1,
  parameter logic [31:0] ICACHE_SZ      = 32'h0,
  parameter logic [31:0] DCACHE_SZ      = 32'h0,
  parameter logic [31:0] MPU_NS_REGIONS = 32'h8,
  parameter logic [31:0] MPU_S_REGIONS  = 32'h8,
  parameter logic [31:0] SAU_REGIONS    = 32'h4
) (
  // Clock and resets
  input  wire logic                    clk_in,
  input  wire logic                    reset_in,
  input  wire logic                    debug_reset_n_in,
  // Register port
  input  wire logic [31:0]             addr_in,
  input  wire logic [31:0]             wdata_in,
  input  wire logic                    wr_in,
  input  wire logic                    rd_in,
  input  wire logic                    priv_in,
  input  wire logic                    nonsecure_in,
  output logic      [31:0]             rdata_out,
  output logic                         bus_fault_out,
  // Security and tie-offs
  input  wire logic                    nonsecure_fault_handling_bit_in,
  input  wire logic [2:0]              port_size_config_input_in,
  input  wire logic                    port_enable_init_input_in,
  input  wire logic                    cfg_fpu_in,
  input  wire logic                    cfg_mve_in,
  input  wire logic                    mpu_ns_disable_in,
  input  wire logic                    mpu_s_disable_in,
  input  wire logic                    sau_disable_in,
  input  wire logic                    l1_reset_disable_in,
  input  wire logic [4:0]              mem_alias_in,
  // Access routing
  input  wire logic                    target_periph_in,
  input  wire logic                    target_vendor_in,
  output logic                         route_to_port_out,
  // Block controls
  output logic                         port_enable_out,
  output logic      [2:0]              port_window_size_out,
  output logic                         prefetch_enable_out,
  output cicr_pkg::cicr_pwr_t          power_request_out
);
  import cicr_pkg::*;

  cicr_state_t state_reg;
  cicr_state_t state_next;

  function automatic cicr_reg_t decode(input logic [31:0] a);
    case (a)
      CICR_ADDR_PORT_CTRL: decode = CICR_R_PORT;
      CICR_ADDR_PF_CTRL:   decode = CICR_R_PF;
      CICR_ADDR_CORE_PWR:  decode = CICR_R_CPWR;
      CICR_ADDR_DBG_PWR:   decode = CICR_R_DPWR;
      CICR_ADDR_CFG_SEL:   decode = CICR_R_CSEL;
      CICR_ADDR_CFG_RD:    decode = CICR_R_CRD;
      default:             decode = CICR_R_NONE;
    endcase
  endfunction

  // Config registers are shared by both security states and never blocked here
  function automatic logic ns_blocked(input cicr_reg_t r, input logic ns,
                                      input logic ns_fault_bit);
    ns_blocked = SECEXT_PRESENT && !ns_fault_bit && ns
                 && (r inside {CICR_R_PORT, CICR_R_PF,
                               CICR_R_CPWR, CICR_R_DPWR});
  endfunction

  function automatic logic [31:0] cfg_item(input logic [31:0] s);
    case (s)
      CICR_CFG_ICACHESZ: cfg_item = ICACHE_SZ;
      CICR_CFG_DCACHESZ: cfg_item = DCACHE_SZ;
      CICR_CFG_ECC:      cfg_item = {31'h0, ECC_PRESENT};
      CICR_CFG_FPU:      cfg_item = {31'h0, FPU_PRESENT & cfg_fpu_in};
      CICR_CFG_MVE:      cfg_item = {31'h0, MVE_PRESENT & cfg_mve_in};
      CICR_CFG_SECEXT:   cfg_item = {31'h0, SECEXT_PRESENT};
      CICR_CFG_MPU_NS:   cfg_item = mpu_ns_disable_in ? 32'h0 : MPU_NS_REGIONS;
      CICR_CFG_MPU_S:    cfg_item = mpu_s_disable_in ? 32'h0 : MPU_S_REGIONS;
      CICR_CFG_SAU:      cfg_item = sau_disable_in ? 32'h0 : SAU_REGIONS;
      CICR_CFG_L1RSTDIS: cfg_item = {31'h0, l1_reset_disable_in};
      CICR_CFG_MEMALIAS: cfg_item = {27'h0, mem_alias_in};
      default:           cfg_item = 32'h0;
    endcase
  endfunction

  cicr_reg_t  acc_reg;
  logic       acc_blocked;
  logic       acc_ok;
  logic [31:0] rd_value;
  logic [1:0] dbg_eff;

  always_comb begin
    acc_reg     = decode(addr_in);
    acc_blocked = ns_blocked(acc_reg, nonsecure_in, nonsecure_fault_handling_bit_in);
    acc_ok      = priv_in && !acc_blocked;
  end

  // Read mux, reserved bits held at zero
  always_comb begin
    rd_value = 32'h0;
    case (acc_reg)
      CICR_R_PORT: begin
        rd_value[CICR_EN_BIT] = state_reg.port_en;
        rd_value[CICR_SIZE_LSB +: 3] = state_reg.port_size;
      end
      CICR_R_PF: begin
        // Lookahead bits never stored
        rd_value[CICR_PF_BIT] = state_reg.pf_en;
      end
      CICR_R_CPWR: begin
        rd_value[CICR_CORE_LSB +: 2] = state_reg.pwr.core;
        rd_value[CICR_EXT_LSB +: 2]  = state_reg.pwr.ext;
        rd_value[CICR_RAM_LSB +: 2]  = state_reg.pwr.ram;
      end
      CICR_R_DPWR: begin
        rd_value[CICR_DBG_LSB +: 2] = state_reg.pwr.dbg;
      end
      CICR_R_CRD: begin
        rd_value = cfg_item(state_reg.sel);
      end
      CICR_R_CSEL: begin
        // Selector is write-only
        rd_value = 32'h0;
      end
      CICR_R_NONE: begin
        rd_value = 32'h0;
      end
      default: begin
        rd_value = 32'h0;
      end
    endcase
  end

  // Next state
  always_comb begin
    state_next = state_reg;
    state_next.fault = 1'b0;
    state_next.rdata = 32'h0;
    if (rd_in) begin
      state_next.rdata = acc_ok ? rd_value : 32'h0;
    end
    if ((rd_in || wr_in) && !priv_in && acc_reg != CICR_R_NONE) begin
      state_next.fault = 1'b1;
    end
    if (wr_in && acc_ok) begin
      case (acc_reg)
        CICR_R_PORT: begin
          // Size field has no write path
          state_next.port_en = wdata_in[CICR_EN_BIT];
        end
        CICR_R_PF: begin
          state_next.pf_en = wdata_in[CICR_PF_BIT];
        end
        CICR_R_CPWR: begin
          state_next.pwr.core = wdata_in[CICR_CORE_LSB +: 2];
          state_next.pwr.ext  = wdata_in[CICR_EXT_LSB +: 2];
          state_next.pwr.ram  = wdata_in[CICR_RAM_LSB +: 2];
        end
        CICR_R_DPWR: begin
          state_next.pwr.dbg = wdata_in[CICR_DBG_LSB +: 2];
        end
        CICR_R_CSEL: begin
          state_next.sel = wdata_in;
        end
        default: begin
          state_next.sel = state_reg.sel;
        end
      endcase
    end
    if (reset_in) begin
      state_next.port_en   = port_enable_init_input_in;
      state_next.port_size = port_size_config_input_in;
      state_next.pf_en     = CICR_PF_RESET;
      state_next.pwr.core  = CICR_PWR_RESET;
      state_next.pwr.ext   = CICR_PWR_RESET;
      state_next.pwr.ram   = CICR_PWR_RESET;
      state_next.sel       = CICR_SEL_RESET;
      state_next.rdata     = 32'h0;
      state_next.fault     = 1'b0;
    end
    if (!debug_reset_n_in) begin
      state_next.pwr.dbg = CICR_PWR_RESET;
    end
    // Absent features pinned to zero, so they read zero and ignore writes
    if (!DCACHE_PRESENT) begin
      state_next.pf_en = 1'b0;
    end
    if (!DCACHE_PRESENT && !ICACHE_PRESENT) begin
      state_next.pwr.ram = CICR_PWR_ON;
    end
    if (!EPU_PRESENT) begin
      state_next.pwr.ext = CICR_PWR_ON;
    end
  end

  always_ff @(posedge clk_in) begin
    state_reg <= state_next;
  end

  // Reserved debug code requested as clock-stopped
  always_comb begin
    dbg_eff = (state_reg.pwr.dbg == CICR_PWR_RET) ? CICR_PWR_CLKOFF
                                                   : state_reg.pwr.dbg;
  end

  // Vendor window ignores the enable bit
  assign route_to_port_out = target_vendor_in
                             || (target_periph_in && state_reg.port_en);

  assign rdata_out            = state_reg.rdata;
  assign bus_fault_out        = state_reg.fault;
  assign port_enable_out      = state_reg.port_en;
  assign port_window_size_out = state_reg.port_size;
  assign prefetch_enable_out  = state_reg.pf_en;
  // Minimum requests only; the power channel decides the real mode
  assign power_request_out.core = state_reg.pwr.core;
  assign power_request_out.ext  = state_reg.pwr.ext;
  assign power_request_out.ram  = state_reg.pwr.ram;
  assign power_request_out.dbg  = dbg_eff;

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_size_loaded: assert property (
    $fell(reset_in) |-> port_window_size_out == $past(port_size_config_input_in))
    else $error("port size not loaded at reset");

  a_enable_init: assert property (
    $fell(reset_in) |-> port_enable_out == $past(port_enable_init_input_in))
    else $error("port enable reset value wrong");

  a_size_readonly: assert property (
    wr_in && decode(addr_in) == CICR_R_PORT |=> $stable(port_window_size_out))
    else $error("port size changed by write");

  a_route_periph: assert property (
    target_periph_in && !target_vendor_in |-> route_to_port_out == port_enable_out)
    else $error("peripheral routing ignores enable");

  a_route_vendor: assert property (
    target_vendor_in |-> route_to_port_out)
    else $error("vendor access not on port");

  a_ns_raz: assert property (
    rd_in && priv_in && acc_blocked |=> rdata_out == 32'h0)
    else $error("blocked non-secure read not zero");

  a_ns_wi: assert property (
    wr_in && acc_blocked && !$past(reset_in)
    |=> $stable(power_request_out) && $stable(port_enable_out)
        && $stable(prefetch_enable_out))
    else $error("blocked non-secure write took effect");

  a_unpriv_fault: assert property (
    (wr_in || rd_in) && !priv_in && decode(addr_in) != CICR_R_NONE
    |=> bus_fault_out && $stable(power_request_out)
        && $stable(port_enable_out)
        ##1 bus_fault_out == $past((wr_in || rd_in) && !priv_in
                                   && decode(addr_in) != CICR_R_NONE))
    else $error("unprivileged access not faulted");

  a_pf_reset: assert property (
    $fell(reset_in) |-> prefetch_enable_out == (DCACHE_PRESENT & CICR_PF_RESET))
    else $error("prefetch enable reset wrong");

  a_pf_read: assert property (
    rd_in && decode(addr_in) == CICR_R_PF |=> rdata_out[31:1] == 31'h0)
    else $error("lookahead bits not zero");

  a_core_reset: assert property (
    $fell(reset_in) |-> power_request_out.core == CICR_PWR_RESET)
    else $error("core request reset wrong");

  a_dbg_reset: assert property (
    !debug_reset_n_in |=> power_request_out.dbg == CICR_PWR_RESET)
    else $error("debug request not reset");

  a_dbg_reserved: assert property (
    power_request_out.dbg != CICR_PWR_RET)
    else $error("reserved debug code passed out");

  a_unmapped_zero: assert property (
    rd_in && decode(addr_in) == CICR_R_NONE |=> rdata_out == 32'h0)
    else $error("unmapped read not zero");

  a_read_once: assert property (
    !rd_in |=> rdata_out == 32'h0)
    else $error("read data outside read slot");

  a_ram_reset: assert property (
    $fell(reset_in) |-> power_request_out.ram
                        == ((DCACHE_PRESENT || ICACHE_PRESENT) ? CICR_PWR_RESET : CICR_PWR_ON))
    else $error("ram request reset wrong");

  a_ext_reset: assert property (
    $fell(reset_in) |-> power_request_out.ext == (EPU_PRESENT ? CICR_PWR_RESET : CICR_PWR_ON))
    else $error("extension request reset wrong");

  a_pf_absent: assert property (
    !DCACHE_PRESENT |-> !prefetch_enable_out)
    else $error("prefetch enabled without data cache");

  a_ram_absent: assert property (
    !DCACHE_PRESENT && !ICACHE_PRESENT |-> power_request_out.ram == CICR_PWR_ON)
    else $error("ram request set without caches");

  a_ext_absent: assert property (
    !EPU_PRESENT |-> power_request_out.ext == CICR_PWR_ON)
    else $error("extension request set without unit");

  a_port_write: assert property (
    wr_in && priv_in && !acc_blocked && decode(addr_in) == CICR_R_PORT
    |=> port_enable_out == $past(wdata_in[CICR_EN_BIT]))
    else $error("port enable write lost");

  a_pf_write: assert property (
    wr_in && priv_in && !acc_blocked && decode(addr_in) == CICR_R_PF
    |=> prefetch_enable_out == (DCACHE_PRESENT && $past(wdata_in[CICR_PF_BIT])))
    else $error("prefetch enable write lost");

  a_core_write: assert property (
    wr_in && priv_in && !acc_blocked && decode(addr_in) == CICR_R_CPWR
    |=> power_request_out.core == $past(wdata_in[CICR_CORE_LSB +: 2]))
    else $error("core request write lost");

  a_dbg_write: assert property (
    wr_in && priv_in && !acc_blocked && debug_reset_n_in
    && decode(addr_in) == CICR_R_DPWR
    |=> power_request_out.dbg
        == ($past(wdata_in[CICR_DBG_LSB +: 2]) == CICR_PWR_RET
            ? CICR_PWR_CLKOFF : $past(wdata_in[CICR_DBG_LSB +: 2])))
    else $error("debug request write wrong");

  a_sel_reads_zero: assert property (
    rd_in && decode(addr_in) == CICR_R_CSEL |=> rdata_out == 32'h0)
    else $error("selector read not zero");

  a_pwr_reserved: assert property (
    rd_in && decode(addr_in) == CICR_R_CPWR
    |=> rdata_out[31:10] == 22'h0 && rdata_out[7:6] == 2'h0 && rdata_out[3:2] == 2'h0)
    else $error("power reserved bits not zero");

  c_port_toggle: cover property (
    wr_in && priv_in && decode(addr_in) == CICR_R_PORT ##1 route_to_port_out);
  c_cfg_read: cover property (
    wr_in && decode(addr_in) == CICR_R_CSEL ##1 rd_in && decode(addr_in) == CICR_R_CRD);
  c_fault: cover property (bus_fault_out);
  c_core_on: cover property (power_request_out.core == CICR_PWR_ON);

endmodule

`default_nettype wire

// file: tb.sv
// Self-checking testbench for the core implementation control register bank.
// Runs a default build beside a build without caches or extension unit.
`timescale 1ns/100ps
`default_nettype none

module tb;
  import cicr_pkg::*;

  logic        clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        debug_reset_n_in = 1'b0;
  logic [31:0] addr_in = 32'h0;
  logic [31:0] wdata_in = 32'h0;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic        priv_in = 1'b1;
  logic        nonsecure_in = 1'b0;
  logic        ns_bit = 1'b0;
  logic [2:0]  size_cfg = 3'h4;
  logic        en_init = 1'b1;
  logic        cfg_fpu = 1'b1;
  logic        mpu_ns_dis = 1'b0;
  logic        sau_dis = 1'b1;
  logic        cfg_mve = 1'b1;
  logic        mpu_s_dis = 1'b0;
  logic        periph = 1'b0;
  logic        vendor = 1'b0;
  logic [31:0] rdata_out;
  logic        bus_fault_out;
  logic        route_out;
  logic        port_en_out;
  logic [2:0]  size_out;
  logic        pf_out;
  cicr_pwr_t   pwr_out;
  logic [31:0] rd_val;
  logic        fault_seen;
  logic [31:0] rdata_bare;
  logic        pf_bare;
  cicr_pwr_t   pwr_bare;
  logic [31:0] rd_bare;
  int          n_errors = 0;
  int          n_tests = 0;

  always #20 clk_in = ~clk_in;

  cicr_regs DUT (
    .clk_in(clk_in), .reset_in(reset_in), .debug_reset_n_in(debug_reset_n_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .priv_in(priv_in), .nonsecure_in(nonsecure_in), .rdata_out(rdata_out),
    .bus_fault_out(bus_fault_out), .nonsecure_fault_handling_bit_in(ns_bit),
    .port_size_config_input_in(size_cfg), .port_enable_init_input_in(en_init),
    .cfg_fpu_in(cfg_fpu), .cfg_mve_in(cfg_mve), .mpu_ns_disable_in(mpu_ns_dis),
    .mpu_s_disable_in(mpu_s_dis), .sau_disable_in(sau_dis), .l1_reset_disable_in(1'b1),
    .mem_alias_in(5'h10), .target_periph_in(periph), .target_vendor_in(vendor),
    .route_to_port_out(route_out), .port_enable_out(port_en_out),
    .port_window_size_out(size_out), .prefetch_enable_out(pf_out),
    .power_request_out(pwr_out)
  );

  // Minimal build shares all inputs; absent fields must stay zero
  cicr_regs #(
    .DCACHE_PRESENT(1'b0), .ICACHE_PRESENT(1'b0), .EPU_PRESENT(1'b0)
  ) dut_bare (
    .clk_in(clk_in), .reset_in(reset_in), .debug_reset_n_in(debug_reset_n_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .priv_in(priv_in), .nonsecure_in(nonsecure_in), .rdata_out(rdata_bare),
    .bus_fault_out(), .nonsecure_fault_handling_bit_in(ns_bit),
    .port_size_config_input_in(size_cfg), .port_enable_init_input_in(en_init),
    .cfg_fpu_in(cfg_fpu), .cfg_mve_in(cfg_mve), .mpu_ns_disable_in(mpu_ns_dis),
    .mpu_s_disable_in(mpu_s_dis), .sau_disable_in(sau_dis), .l1_reset_disable_in(1'b1),
    .mem_alias_in(5'h10), .target_periph_in(periph), .target_vendor_in(vendor),
    .route_to_port_out(), .port_enable_out(), .port_window_size_out(),
    .prefetch_enable_out(pf_bare), .power_request_out(pwr_bare)
  );

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Strobe high for one cycle; the answer is taken just after the next edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic p, input logic ns);
    @(posedge clk_in);
    wr_in <= w;
    rd_in <= ~w;
    addr_in <= a;
    wdata_in <= d;
    priv_in <= p;
    nonsecure_in <= ns;
    @(posedge clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    #1;
    rd_val = rdata_out;
    fault_seen = bus_fault_out;
    rd_bare = rdata_bare;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 1'b1, 1'b0);
  endtask

  task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 1'b1, 1'b0);
    check(what, rd_val, exp);
  endtask

  task automatic cfg_chk(input logic [31:0] code, input logic [31:0] exp);
    wr(CICR_ADDR_CFG_SEL, code);
    rd_chk("config_item_readback", CICR_ADDR_CFG_RD, exp);
  endtask

  // Either reset may be pulsed alone to show the two domains are separate
  task automatic do_reset(input logic func, input logic dbg);
    @(posedge clk_in);
    reset_in <= func;
    debug_reset_n_in <= ~dbg;
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    debug_reset_n_in <= 1'b1;
    #1;
  endtask

  task automatic route_chk(input logic en);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      periph <= i[0];
      vendor <= i[1];
      #1;
      check("route_to_port_out", {31'h0, route_out}, {31'h0, i[1] | (i[0] & en)});
    end
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_in);
    n_errors++;
    end_sim;
  end

  initial begin
    do_reset(1'b1, 1'b1);
    rd_chk("port ctrl reset", CICR_ADDR_PORT_CTRL, 32'h9);
    check("port_enable_out", {31'h0, port_en_out}, 32'h1);
    check("size_out", {29'h0, size_out}, 32'h4);
    rd_chk("prefetch reset", CICR_ADDR_PF_CTRL, 32'h1);
    rd_chk("core pwr reset", CICR_ADDR_CORE_PWR, 32'h333);
    rd_chk("debug pwr reset", CICR_ADDR_DBG_PWR, 32'h3);
    check("power_request_out", {24'h0, pwr_out}, 32'hff);
    check("bare power_request_out", {24'h0, pwr_bare}, 32'hc3);
    check("bare prefetch_enable_out", {31'h0, pf_bare}, 32'h0);
    $display("test reset values done");

    // Size field must ignore a write of zeros, reserved bits a write of ones
    wr(CICR_ADDR_PORT_CTRL, 32'hfffffff0);
    rd_chk("port ctrl off", CICR_ADDR_PORT_CTRL, 32'h8);
    check("port_enable_out", {31'h0, port_en_out}, 32'h0);
    route_chk(1'b0);
    wr(CICR_ADDR_PORT_CTRL, 32'h1);
    rd_chk("port ctrl on", CICR_ADDR_PORT_CTRL, 32'h9);
    route_chk(1'b1);
    $display("test port control done");

    wr(CICR_ADDR_PF_CTRL, 32'h7e);
    rd_chk("prefetch off", CICR_ADDR_PF_CTRL, 32'h0);
    check("prefetch_enable_out", {31'h0, pf_out}, 32'h0);
    wr(CICR_ADDR_PF_CTRL, 32'hffffffff);
    rd_chk("prefetch on", CICR_ADDR_PF_CTRL, 32'h1);
    check("bare prefetch read", rd_bare, 32'h0);
    check("prefetch_enable_out", {31'h0, pf_out}, 32'h1);
    $display("test prefetcher done");

    for (int c = 0; c < 4; c++) begin
      wr(CICR_ADDR_CORE_PWR, 32'hfffffccc | (c << 8) | (c << 4) | c);
      rd_chk("core pwr", CICR_ADDR_CORE_PWR, (c << 8) | (c << 4) | c);
      check("bare core pwr", rd_bare, c);
      check("pwr core ext ram", {26'h0, pwr_out[7:2]}, c * 32'h15);
      wr(CICR_ADDR_DBG_PWR, 32'hfffffffc | c);
      rd_chk("debug pwr", CICR_ADDR_DBG_PWR, c);
      check("pwr dbg", {30'h0, pwr_out.dbg}, (c == 2) ? 32'h1 : c);
    end
    $display("test power requests done");

    // Secure-only mode: non-secure traffic sees zero and cannot write; with ns_bit set it can
    bus(1'b1, CICR_ADDR_CORE_PWR, 32'h0, 1'b1, 1'b1);
    check("ns write fault", {31'h0, fault_seen}, 32'h0);
    bus(1'b0, CICR_ADDR_CORE_PWR, 32'h0, 1'b1, 1'b1);
    check("ns read", rd_val, 32'h0);
    rd_chk("core pwr kept", CICR_ADDR_CORE_PWR, 32'h333);
    ns_bit <= 1'b1;
    bus(1'b1, CICR_ADDR_CORE_PWR, 32'h100, 1'b1, 1'b1);
    bus(1'b0, CICR_ADDR_CORE_PWR, 32'h0, 1'b1, 1'b1);
    check("ns read open", rd_val, 32'h100);
    $display("test security done");

    bus(1'b1, CICR_ADDR_CORE_PWR, 32'h0, 1'b0, 1'b0);
    check("user write fault", {31'h0, fault_seen}, 32'h1);
    bus(1'b0, CICR_ADDR_CORE_PWR, 32'h0, 1'b0, 1'b0);
    check("user read fault", {31'h0, fault_seen}, 32'h1);
    check("user read data", rd_val, 32'h0);
    rd_chk("core pwr kept", CICR_ADDR_CORE_PWR, 32'h100);
    check("priv read fault", {31'h0, fault_seen}, 32'h0);
    rd_chk("unmapped", 32'he001e308, 32'h0);
    $display("test privilege done");

    cfg_chk(CICR_CFG_FPU, 32'h1);
    cfg_fpu <= 1'b0;
    cfg_chk(CICR_CFG_FPU, 32'h0);
    cfg_chk(CICR_CFG_MPU_NS, 32'h8);
    mpu_ns_dis <= 1'b1;
    cfg_chk(CICR_CFG_MPU_NS, 32'h0);
    cfg_chk(CICR_CFG_SAU, 32'h0);
    sau_dis <= 1'b0;
    cfg_chk(CICR_CFG_SAU, 32'h4);
    cfg_chk(CICR_CFG_MVE, 32'h1);
    cfg_mve <= 1'b0;
    cfg_chk(CICR_CFG_MVE, 32'h0);
    cfg_chk(CICR_CFG_MPU_S, 32'h8);
    mpu_s_dis <= 1'b1;
    cfg_chk(CICR_CFG_MPU_S, 32'h0);
    cfg_chk(CICR_CFG_ICACHESZ, 32'h0);
    cfg_chk(CICR_CFG_DCACHESZ, 32'h0);
    cfg_chk(CICR_CFG_ECC, 32'h0);
    cfg_chk(CICR_CFG_SECEXT, 32'h1);
    cfg_chk(CICR_CFG_L1RSTDIS, 32'h1);
    cfg_chk(CICR_CFG_MEMALIAS, 32'h10);
    cfg_chk(32'h7, 32'h0);
    rd_chk("selector read", CICR_ADDR_CFG_SEL, 32'h0);
    $display("test config readback done");

    // Functional reset must leave the debug request alone, and vice versa
    wr(CICR_ADDR_DBG_PWR, 32'h1);
    size_cfg <= 3'h0;
    en_init <= 1'b0;
    do_reset(1'b1, 1'b0);
    rd_chk("debug kept", CICR_ADDR_DBG_PWR, 32'h1);
    rd_chk("port ctrl zero", CICR_ADDR_PORT_CTRL, 32'h0);
    rd_chk("core pwr reset", CICR_ADDR_CORE_PWR, 32'h333);
    wr(CICR_ADDR_CORE_PWR, 32'h0);
    do_reset(1'b0, 1'b1);
    rd_chk("debug reset", CICR_ADDR_DBG_PWR, 32'h3);
    rd_chk("core kept", CICR_ADDR_CORE_PWR, 32'h0);
    $display("test resets done");
    end_sim;
  end

endmodule

`default_nettype wire
